/* File: inc/pie_pkg.sv */
// Constants, types and helpers shared by the peripheral interrupt enable bank.
package pie_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    typedef logic [DATA_W-1:0] pie_byte_t;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [ADDR_W-1:0]    addr;
        pie_byte_t            wdata;
    } pie_bus_t;

    localparam logic [ADDR_W-1:0] ADDR_ENABLE  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_REQ     = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_EN_SET  = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_EN_CLR  = 4'h6;

    localparam int BIT_CAPCMP5 = 6;
    localparam int BIT_CAPCMP4 = 5;
    localparam int BIT_CAPCMP3 = 4;
    localparam int BIT_TIMER6  = 3;
    localparam int BIT_TIMER4  = 1;

    localparam pie_byte_t IMPL_MASK  = 8'h7A;
    localparam pie_byte_t RESET_VAL  = 8'h00;
    localparam pie_byte_t READ_IDLE  = 8'h00;
    localparam pie_byte_t ALL_ONES   = 8'hFF;

    // Keeps only the implemented bit positions of a register value.
    function automatic pie_byte_t impl_only(input pie_byte_t v);
        return v & IMPL_MASK;
    endfunction

endpackage

/* File: verilog/pie_event_reg.sv */
// Sticky event bits where a set in the same cycle wins over a clear.
`timescale 1ns/10ps
module pie_event_reg (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire pie_pkg::pie_byte_t set_bits,
    input  wire pie_pkg::pie_byte_t clr_bits,
    output pie_pkg::pie_byte_t      q
);

    pie_pkg::pie_byte_t next_q;

    always_comb begin
        next_q = pie_pkg::impl_only((q & ~clr_bits) | set_bits);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= pie_pkg::RESET_VAL;
        end else begin
            q <= next_q;
        end
    end

endmodule

/* File: verilog/pie_gate.sv */
// Registered bitwise gate of two vectors and the registered OR of the result.
`timescale 1ns/10ps
module pie_gate (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire pie_pkg::pie_byte_t a,
    input  wire pie_pkg::pie_byte_t b,
    output pie_pkg::pie_byte_t      gated,
    output logic                    any
);

    pie_pkg::pie_byte_t next_gated;

    always_comb begin
        next_gated = pie_pkg::impl_only(a & b);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gated <= pie_pkg::RESET_VAL;
            any   <= 1'b0;
        end else begin
            gated <= next_gated;
            any   <= |next_gated;
        end
    end

endmodule

/* File: verilog/pie_enable_bank.sv */
// Peripheral interrupt enable bank three with pending flags, sticky status and register port.
//
// Behaviour
// - Fifth capture/compare request passes to irq_req_vec and periph_irq_req only while enable bit 6 is one; irq is gated by mask bit 6 instead.
// - Fourth capture/compare request passes to irq_req_vec and periph_irq_req only while writable enable bit 5 is one; irq is gated by mask bit 5 instead.
// - Third capture/compare request passes to irq_req_vec and periph_irq_req only while enable bit 4 is one; irq is gated by mask bit 4 instead.
// - Timer six period match request passes to irq_req_vec and periph_irq_req only while enable bit 3 is one; irq is gated by mask bit 3 instead.
// - Timer four period match request passes to irq_req_vec and periph_irq_req only while enable bit 1 is one; irq is gated by mask bit 1 instead.
// - Bits 7, 2 and 0 are unimplemented: read zero, writes ignored.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module pie_enable_bank (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire pie_pkg::pie_bus_t bus,
    output pie_pkg::pie_byte_t      rdata,
    input  wire logic              capcmp5_event,
    input  wire logic              capcmp4_event,
    input  wire logic              capcmp3_event,
    input  wire logic              timer6_match_event,
    input  wire logic              timer4_match_event,
    output pie_pkg::pie_byte_t      irq_req_vec,
    output logic                    periph_irq_req,
    output logic                    irq
);

    pie_pkg::pie_byte_t peripheral_irq_enable_3;
    pie_pkg::pie_byte_t src_events;
    pie_pkg::pie_byte_t flags;
    pie_pkg::pie_byte_t flag_clr;
    pie_pkg::pie_byte_t status;
    pie_pkg::pie_byte_t status_clr;
    pie_pkg::pie_byte_t mask;
    pie_pkg::pie_byte_t next_rdata;
    logic               capcmp5_irq_en;
    logic               capcmp4_irq_en;
    logic               capcmp3_irq_en;
    logic               timer6_match_irq_en;
    logic               timer4_match_irq_en;
    logic               next_capcmp5_irq_en;
    logic               next_capcmp4_irq_en;
    logic               next_capcmp3_irq_en;
    logic               next_timer6_match_irq_en;
    logic               next_timer4_match_irq_en;
    logic               capcmp5_irq_mask;
    logic               capcmp4_irq_mask;
    logic               capcmp3_irq_mask;
    logic               timer6_match_irq_mask;
    logic               timer4_match_irq_mask;
    logic               next_capcmp5_irq_mask;
    logic               next_capcmp4_irq_mask;
    logic               next_capcmp3_irq_mask;
    logic               next_timer6_match_irq_mask;
    logic               next_timer4_match_irq_mask;

    // True when the bus writes the given register in this cycle.
    function automatic logic wr_hit(input pie_pkg::pie_bus_t b, input logic [pie_pkg::ADDR_W-1:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // True when the bus reads the given register in this cycle.
    function automatic logic rd_hit(input pie_pkg::pie_bus_t b, input logic [pie_pkg::ADDR_W-1:0] a);
        return b.rd && (b.addr == a);
    endfunction

    // Next value of one enable bit: a direct write, or a set or clear through the aliases.
    function automatic logic enable_bit_next(input logic cur, input pie_pkg::pie_bus_t b, input int pos);
        logic nxt;
        nxt = cur;
        if (wr_hit(b, pie_pkg::ADDR_ENABLE)) begin
            nxt = b.wdata[pos];
        end else if (wr_hit(b, pie_pkg::ADDR_EN_SET) && b.wdata[pos]) begin
            nxt = 1'b1;
        end else if (wr_hit(b, pie_pkg::ADDR_EN_CLR) && b.wdata[pos]) begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    // Next value of one mask bit: only a direct write of the mask register moves it.
    function automatic logic mask_bit_next(input logic cur, input pie_pkg::pie_bus_t b, input int pos);
        logic nxt;
        nxt = cur;
        if (wr_hit(b, pie_pkg::ADDR_MASK)) begin
            nxt = b.wdata[pos];
        end
        return nxt;
    endfunction

    // Places each source event at the bit position of its enable bit.
    always_comb begin
        src_events                       = pie_pkg::RESET_VAL;
        src_events[pie_pkg::BIT_CAPCMP5] = capcmp5_event;
        src_events[pie_pkg::BIT_CAPCMP4] = capcmp4_event;
        src_events[pie_pkg::BIT_CAPCMP3] = capcmp3_event;
        src_events[pie_pkg::BIT_TIMER6]  = timer6_match_event;
        src_events[pie_pkg::BIT_TIMER4]  = timer4_match_event;
    end

    // Next values of the enable bits; bits 7, 2 and 0 have no storage at all.
    always_comb begin
        next_capcmp5_irq_en      = enable_bit_next(capcmp5_irq_en, bus, pie_pkg::BIT_CAPCMP5);
        next_capcmp4_irq_en      = enable_bit_next(capcmp4_irq_en, bus, pie_pkg::BIT_CAPCMP4);
        next_capcmp3_irq_en      = enable_bit_next(capcmp3_irq_en, bus, pie_pkg::BIT_CAPCMP3);
        next_timer6_match_irq_en = enable_bit_next(timer6_match_irq_en, bus, pie_pkg::BIT_TIMER6);
        next_timer4_match_irq_en = enable_bit_next(timer4_match_irq_en, bus, pie_pkg::BIT_TIMER4);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp5_irq_en <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP5];
        end else begin
            capcmp5_irq_en <= next_capcmp5_irq_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp4_irq_en <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP4];
        end else begin
            capcmp4_irq_en <= next_capcmp4_irq_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp3_irq_en <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP3];
        end else begin
            capcmp3_irq_en <= next_capcmp3_irq_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer6_match_irq_en <= pie_pkg::RESET_VAL[pie_pkg::BIT_TIMER6];
        end else begin
            timer6_match_irq_en <= next_timer6_match_irq_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer4_match_irq_en <= pie_pkg::RESET_VAL[pie_pkg::BIT_TIMER4];
        end else begin
            timer4_match_irq_en <= next_timer4_match_irq_en;
        end
    end

    // Enable register view: implemented bits in place, unimplemented bits tied low.
    always_comb begin
        peripheral_irq_enable_3                       = pie_pkg::READ_IDLE;
        peripheral_irq_enable_3[pie_pkg::BIT_CAPCMP5] = capcmp5_irq_en;
        peripheral_irq_enable_3[pie_pkg::BIT_CAPCMP4] = capcmp4_irq_en;
        peripheral_irq_enable_3[pie_pkg::BIT_CAPCMP3] = capcmp3_irq_en;
        peripheral_irq_enable_3[pie_pkg::BIT_TIMER6]  = timer6_match_irq_en;
        peripheral_irq_enable_3[pie_pkg::BIT_TIMER4]  = timer4_match_irq_en;
    end

    // Pending flags: set by source events, cleared by writing ones; enable plays no part.
    always_comb begin
        flag_clr = pie_pkg::RESET_VAL;
        if (wr_hit(bus, pie_pkg::ADDR_FLAGS)) begin
            flag_clr = bus.wdata;
        end
    end

    pie_event_reg u_flags (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .set_bits (src_events),
        .clr_bits (flag_clr),
        .q        (flags)
    );

    // Gated requests toward the core; master enable lives in the core.
    pie_gate u_req_gate (
        .clk_sys (clk_sys),
        .rst     (rst),
        .a       (flags),
        .b       (peripheral_irq_enable_3),
        .gated   (irq_req_vec),
        .any     (periph_irq_req)
    );

    // Sticky event status, cleared by a read of the status register.
    always_comb begin
        status_clr = pie_pkg::RESET_VAL;
        if (rd_hit(bus, pie_pkg::ADDR_STATUS)) begin
            status_clr = pie_pkg::ALL_ONES;
        end
    end

    pie_event_reg u_status (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .set_bits (src_events),
        .clr_bits (status_clr),
        .q        (status)
    );

    // Next values of the mask bits, in the same layout as the enable bits.
    always_comb begin
        next_capcmp5_irq_mask      = mask_bit_next(capcmp5_irq_mask, bus, pie_pkg::BIT_CAPCMP5);
        next_capcmp4_irq_mask      = mask_bit_next(capcmp4_irq_mask, bus, pie_pkg::BIT_CAPCMP4);
        next_capcmp3_irq_mask      = mask_bit_next(capcmp3_irq_mask, bus, pie_pkg::BIT_CAPCMP3);
        next_timer6_match_irq_mask = mask_bit_next(timer6_match_irq_mask, bus, pie_pkg::BIT_TIMER6);
        next_timer4_match_irq_mask = mask_bit_next(timer4_match_irq_mask, bus, pie_pkg::BIT_TIMER4);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp5_irq_mask <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP5];
        end else begin
            capcmp5_irq_mask <= next_capcmp5_irq_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp4_irq_mask <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP4];
        end else begin
            capcmp4_irq_mask <= next_capcmp4_irq_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capcmp3_irq_mask <= pie_pkg::RESET_VAL[pie_pkg::BIT_CAPCMP3];
        end else begin
            capcmp3_irq_mask <= next_capcmp3_irq_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer6_match_irq_mask <= pie_pkg::RESET_VAL[pie_pkg::BIT_TIMER6];
        end else begin
            timer6_match_irq_mask <= next_timer6_match_irq_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer4_match_irq_mask <= pie_pkg::RESET_VAL[pie_pkg::BIT_TIMER4];
        end else begin
            timer4_match_irq_mask <= next_timer4_match_irq_mask;
        end
    end

    // Mask register view with the unimplemented bits tied low.
    always_comb begin
        mask                       = pie_pkg::READ_IDLE;
        mask[pie_pkg::BIT_CAPCMP5] = capcmp5_irq_mask;
        mask[pie_pkg::BIT_CAPCMP4] = capcmp4_irq_mask;
        mask[pie_pkg::BIT_CAPCMP3] = capcmp3_irq_mask;
        mask[pie_pkg::BIT_TIMER6]  = timer6_match_irq_mask;
        mask[pie_pkg::BIT_TIMER4]  = timer4_match_irq_mask;
    end

    pie_gate u_irq_gate (
        .clk_sys (clk_sys),
        .rst     (rst),
        .a       (status),
        .b       (mask),
        .gated   (),
        .any     (irq)
    );

    // Read data stands in the cycle after the read strobe only.
    always_comb begin
        next_rdata = pie_pkg::READ_IDLE;
        if (bus.rd) begin
            case (bus.addr)
                pie_pkg::ADDR_ENABLE: begin
                    next_rdata = peripheral_irq_enable_3;
                end
                pie_pkg::ADDR_FLAGS: begin
                    next_rdata = flags;
                end
                pie_pkg::ADDR_STATUS: begin
                    next_rdata = status;
                end
                pie_pkg::ADDR_MASK: begin
                    next_rdata = mask;
                end
                pie_pkg::ADDR_REQ: begin
                    next_rdata = irq_req_vec;
                end
                default: begin
                    next_rdata = pie_pkg::READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= pie_pkg::READ_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

/* File: test/pie_chk.sv */
// Port assertions for the peripheral interrupt enable bank.
`timescale 1ns/10ps
module pie_chk (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire pie_pkg::pie_bus_t  bus,
    input wire pie_pkg::pie_byte_t rdata,
    input wire pie_pkg::pie_byte_t irq_req_vec,
    input wire logic               periph_irq_req,
    input wire logic               irq
);
    pie_pkg::pie_byte_t en;
    // Shadow of the enable register, rebuilt from the bus writes.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en <= 8'h00;
        end else if (bus.wr) begin
            case (bus.addr)
                4'h0: en <= bus.wdata & 8'h7A;
                4'h5: en <= en | (bus.wdata & 8'h7A);
                4'h6: en <= en & ~bus.wdata;
                default: en <= en;
            endcase
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_cap5_gate: assert property (irq_req_vec[6] |-> $past(en[6])) else $error("cap5 leak");
    a_cap4_gate: assert property (irq_req_vec[5] |-> $past(en[5])) else $error("cap4 leak");
    a_cap3_gate: assert property (irq_req_vec[4] |-> $past(en[4])) else $error("cap3 leak");
    a_timer_six_count_gate: assert property (irq_req_vec[3] |-> $past(en[3])) else $error("timer_six_count leak");
    a_timer_four_count_gate: assert property (irq_req_vec[1] |-> $past(en[1])) else $error("timer_four_count leak");
    a_unimpl_zero: assert property (((rdata | irq_req_vec) & 8'h85) == 8'h00) else $error("bad bit");
    a_periph_or: assert property (periph_irq_req == (|irq_req_vec)) else $error("or wrong");
    a_enable_rdbk: assert property (bus.rd && bus.addr == 4'h0 |=> rdata == $past(en)) else $error("rdbk");
    cover property (irq);
    cover property (periph_irq_req ##1 !periph_irq_req);
    cover property (bus.rd && bus.addr == 4'h2);
endmodule
bind pie_enable_bank pie_chk u_chk (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .bus            (bus),
    .rdata          (rdata),
    .irq_req_vec    (irq_req_vec),
    .periph_irq_req (periph_irq_req),
    .irq            (irq)
);

/* File: test/pie_src_model.sv */
// Source and processor side model facing the enable bank.
`timescale 1ns/10ps
module pie_src_model (
    input  wire logic       clk_sys,
    input  wire logic [4:0] fire,
    input  wire logic       master_en,
    input  wire logic       periph_irq_req,
    output logic [4:0]      ev,
    output logic            cpu_int
);
    always_ff @(posedge clk_sys) begin
        ev <= fire;
    end
    assign cpu_int = periph_irq_req & master_en;
endmodule

/* File: test/pie_enable_bank_bench.sv */
// Self-checking bench for the peripheral interrupt enable bank.
`timescale 1ns/10ps
module pie_enable_bank_bench;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    pie_pkg::pie_bus_t  bus = '0;
    pie_pkg::pie_byte_t rdata;
    pie_pkg::pie_byte_t irq_req_vec;
    logic               periph_irq_req;
    logic               irq;
    logic               master_en = 1'b0;
    logic               cpu_int;
    logic [4:0]         fire = '0;
    logic [4:0]         ev;
    int                 failures = 0;
    int                 n_checks = 0;
    int                 bitpos[5] = '{6, 5, 4, 3, 1};
    always #10 clk_sys = ~clk_sys;
    pie_src_model model (.clk_sys(clk_sys), .fire(fire), .master_en(master_en),
        .periph_irq_req(periph_irq_req), .ev(ev), .cpu_int(cpu_int));
    pie_enable_bank uut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .capcmp5_event(ev[4]),
        .capcmp4_event(ev[3]), .capcmp3_event(ev[2]), .timer6_match_event(ev[1]), .timer4_match_event(ev[0]),
        .irq_req_vec(irq_req_vec), .periph_irq_req(periph_irq_req), .irq(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        #1 chk(rdata, exp, what);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        fire <= 5'h10 >> k;
        @(posedge clk_sys);
        fire <= '0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        int k;
        int w;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h0, 8'h00, "en rst");
        rd(4'hF, 8'h00, "unmapped");
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'h7A, "en wr");
        wr(4'h0, 8'h00);
        for (k = 0; k < 5; k++) begin
            pulse(k);
            step(3);
            chk(irq_req_vec, 8'h00, "blk");
            wr(4'h5, 8'h01 << bitpos[k]);
            step(2);
            chk(irq_req_vec, 8'h01 << bitpos[k], "pass");
            chk({7'h00, periph_irq_req}, 8'h01, "req");
            rd(4'h4, 8'h01 << bitpos[k], "req reg");
            wr(4'h6, 8'hFF);
            step(2);
            chk({7'h00, periph_irq_req}, 8'h00, "drop");
            rd(4'h1, 8'h01 << bitpos[k], "flag");
            wr(4'h1, 8'hFF);
        end
        rd(4'h2, 8'h7A, "status");
        wr(4'h3, 8'h40);
        rd(4'h3, 8'h40, "mask rdbk");
        rd(4'h5, 8'h00, "alias rd");
        wr(4'h5, 8'h40);
        pulse(0);
        for (w = 0; w < 8 && irq !== 1'b1; w++) step(1);
        if (irq !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: irq never rose", $time);
        end else begin
            chk({7'h00, cpu_int}, 8'h00, "core off");
            master_en <= 1'b1;
            step(1);
            chk({7'h00, cpu_int}, 8'h01, "core on");
            rd(4'h2, 8'h40, "st read");
            step(2);
            chk({7'h00, irq}, 8'h00, "irq clr");
            wr(4'h3, 8'h00);
            pulse(0);
            step(3);
            chk({7'h00, irq}, 8'h00, "masked");
        end
        close_out();
    end
endmodule
